// *** design/cps_decim.sv ***
// Purpose: averages three times the ratio of modulator samples per stage
// Assumes: one sample per i_tick
// Notes:   result is ones count scaled to full 16-bit span
`timescale 1ns/1ps
`include "cps_consts.svh"
module cps_decim import cps_pkg::*; (
    input  wire logic                  i_clk,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_clear,
    input  wire logic                  i_tick,
    input  wire logic                  i_bit,
    input  wire logic                  i_half,
    output logic                       o_done,
    output logic [`CPS_RES_W-1:0]      o_result
);
    logic [9:0]  n_reg;
    logic [9:0]  ones_reg;
    wire  [9:0]  target   = i_half ? 10'(`CPS_N_LO - 1) : 10'(`CPS_N_HI - 1);
    wire  [9:0]  ones_tot = ones_reg + {9'h000, i_bit};
    wire  [7:0]  scale    = i_half ? `CPS_SCALE_LO : `CPS_SCALE_HI;
    wire  [17:0] prod     = ones_tot * scale;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n || i_clear) begin
            n_reg    <= 10'h000;
            ones_reg <= 10'h000;
            o_done   <= 1'b0;
        end else begin
            o_done <= 1'b0;
            if (i_tick) begin
                if (n_reg == target) begin
                    n_reg    <= 10'h000;
                    ones_reg <= 10'h000;
                    o_done   <= 1'b1;
                end else begin
                    n_reg    <= n_reg + 10'h001;
                    ones_reg <= ones_tot;
                end
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_result <= 16'h0000;
        end else if (i_tick && n_reg == target) begin
            o_result <= prod[`CPS_RES_W-1:0];
        end
    end

    chk_ones_bound : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        ones_reg <= n_reg)
        else $error("more ones than samples");
endmodule : cps_decim

// *** design/cps_seq_top.sv ***
// Purpose: stage sequencer, input routing and trim control of the converter
// Assumes: AHB-Lite single word transfers, one slave on the bus
// Notes:   every access has one wait state
//
// The register addresses and the AHB-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "cps_consts.svh"
// Summary of operation
// - each pin per stage goes to positive, negative, open or guard drive
// - each pin's routing is a two-bit field in its stage register
// - routing is held separately for every stage and every pin
// - pin on positive input makes the stage code fall on touch
// - pin on negative input makes the stage code rise on touch
// - each stage result is 16 bits from one of fourteen inputs
// - modulator samples at 250 kHz, the time base of all stages
// - control bits 9:8 pick ratio 256 (00) or 128 (01)
// - a stage lasts 3.072 ms at 256 and 1.536 ms at 128
// - each result averages three times the ratio of samples
// - two 7-bit trim codes per stage drive the offset converters
// - each trim code may go to either converter input
// - up to twelve stages, each with its own configuration
// - sequences start at stage zero and step up to the last stage
// - last-stage value N gives N+1 stages per sequence; values above 11 are clamped to 11, giving twelve stages
// - sequence time is stage count times stage time
// - a differential pair reports at most one button active
// - full power repeats sequences continuously at constant rate
module cps_seq_top import cps_pkg::*; #(
    parameter int STAGE_CYC_HI = `CPS_T_STG_HI_NS / `CPS_CLK_NS
) (
    input  wire logic                  i_clk,
    input  wire logic                  i_reset_n,
    input  wire logic                  i_hsel,
    input  wire logic [31:0]           i_haddr,
    input  wire logic [1:0]            i_htrans,
    input  wire logic                  i_hwrite,
    input  wire logic [2:0]            i_hsize,
    input  wire logic [31:0]           i_hwdata,
    input  wire logic                  i_hready,
    input  wire logic                  i_mod_bit,
    output logic [31:0]                o_hrdata,
    output logic                       o_hreadyout,
    output logic                       o_hresp,
    output logic [`CPS_PINS-1:0]       o_pin_pos,
    output logic [`CPS_PINS-1:0]       o_pin_neg,
    output logic [`CPS_PINS-1:0]       o_pin_guard,
    output cps_trim_s                  o_trim,
    output logic [`CPS_STG_W-1:0]      o_stage,
    output logic                       o_cal_en,
    output logic [`CPS_RES_W-1:0]      o_result,
    output logic                       o_result_valid,
    output logic                       o_seq_done,
    output logic                       o_btn_a,
    output logic                       o_btn_b
);
    localparam int STAGE_CYC_LO = STAGE_CYC_HI / 2;

    ////////////////////////////////////////////////////////////////////
    // bus slave
    logic                     ph_reg;
    logic [11:0]              addr_reg;
    logic                     wr_reg;
    logic [1:0]               dec_reg;
    logic [`CPS_STG_W-1:0]    last_reg;
    logic [`CPS_STAGES-1:0]   calen_reg;
    logic [`CPS_ROUTE_W-1:0]  route_mem [`CPS_STAGES];
    cps_trim_s                trim_mem  [`CPS_STAGES];
    logic [`CPS_RES_W-1:0]    res_mem   [`CPS_STAGES];

    cps_state_e               state_reg;
    logic [`CPS_STG_W-1:0]    stage_reg;
    logic [7:0]               seq_cnt_reg;
    logic [`CPS_CYC_W-1:0]    cyc_reg;
    logic                     dec_done;
    logic [`CPS_RES_W-1:0]    dec_res;
    logic                     tick;
    logic                     mod_bit;

    wire accept = i_hsel & i_htrans[1] & i_hready;
    wire do_wr  = ph_reg & wr_reg;
    wire do_rd  = ph_reg & ~wr_reg;

    wire                  in_stg = (addr_reg >= `CPS_A_STG_BASE) && (addr_reg <= `CPS_A_STG_END);
    wire [`CPS_STG_W-1:0] a_stg  = addr_reg[7:4] - `CPS_STG_IDX_OFS;
    wire [1:0]            a_word = addr_reg[3:2];
    wire wr_ctrl  = do_wr && addr_reg == `CPS_A_CTRL;
    wire wr_last  = do_wr && addr_reg == `CPS_A_LAST;
    wire wr_calen = do_wr && addr_reg == `CPS_A_CALEN;
    wire wr_route = do_wr && in_stg && a_word == `CPS_W_ROUTE;
    wire wr_trim  = do_wr && in_stg && a_word == `CPS_W_TRIM;

    wire run     = (state_reg == ST_RUN);
    wire half    = (dec_reg == `CPS_DEC_128);
    wire restart = wr_ctrl | wr_last;

    wire [15:0] status = {seq_cnt_reg, 3'h0, run, stage_reg};
    wire [31:0] stg_rd =
        (a_word == `CPS_W_ROUTE) ? {4'h0, route_mem[a_stg]} :
        (a_word == `CPS_W_TRIM)  ? trim_mem[a_stg] :
        (a_word == `CPS_W_RES)   ? {16'h0000, res_mem[a_stg]} : 32'h0000_0000;
    wire [31:0] rd_data =
        (addr_reg == `CPS_A_CTRL)  ? {22'h00_0000, dec_reg, 8'h00} :
        (addr_reg == `CPS_A_LAST)  ? {28'h000_0000, last_reg} :
        (addr_reg == `CPS_A_CALEN) ? {20'h0_0000, calen_reg} :
        (addr_reg == `CPS_A_STAT)  ? {16'h0000, status} :
        in_stg                     ? stg_rd : 32'h0000_0000;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            ph_reg      <= 1'b0;
            o_hreadyout <= 1'b1;
            o_hresp     <= 1'b0;
            addr_reg    <= 12'h000;
            wr_reg      <= 1'b0;
        end else begin
            ph_reg      <= accept;
            o_hreadyout <= ~accept;
            o_hresp     <= 1'b0;
            if (accept) begin
                addr_reg <= i_haddr[11:0];
                wr_reg   <= i_hwrite;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_hrdata <= 32'h0000_0000;
        end else if (do_rd) begin
            o_hrdata <= rd_data;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            dec_reg   <= 2'h0;
            last_reg  <= `CPS_LAST_RST;
            calen_reg <= '0;
        end else begin
            if (wr_ctrl) dec_reg <= i_hwdata[`CPS_DEC_LSB+1:`CPS_DEC_LSB];
            if (wr_last) last_reg <= i_hwdata[`CPS_STG_W-1:0];
            if (wr_calen) calen_reg <= i_hwdata[`CPS_STAGES-1:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            for (int s = 0; s < `CPS_STAGES; s++) begin
                route_mem[s] <= `CPS_ROUTE_RST;
                trim_mem[s]  <= cps_trim_s'(32'h0000_0000);
            end
        end else begin
            if (wr_route) route_mem[a_stg] <= i_hwdata[`CPS_ROUTE_W-1:0];
            if (wr_trim) trim_mem[a_stg] <= cps_trim_s'(i_hwdata & `CPS_TRIM_MASK);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // converter timing and averaging
    // sample time base
    cps_tick u_tick (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_clear   (~run),
        .i_mod_bit (i_mod_bit),
        .o_tick    (tick),
        .o_bit     (mod_bit)
    );

    cps_decim u_decim (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_clear   (~run),
        .i_tick    (tick),
        .i_bit     (mod_bit),
        .i_half    (half),
        .o_done    (dec_done),
        .o_result  (dec_res)
    );

    ////////////////////////////////////////////////////////////////////
    // stage sequencer
    // at most twelve stages
    wire [`CPS_STG_W-1:0] last_eff   = (last_reg > `CPS_LAST_MAX) ? `CPS_LAST_MAX : last_reg;
    wire                  at_last    = (stage_reg >= last_eff);
    wire [`CPS_STG_W-1:0] stage_next = at_last ? '0 : stage_reg + 4'h1;
    wire                  stg_done   = run & dec_done & ~restart;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            state_reg   <= ST_IDLE;
            stage_reg   <= '0;
            seq_cnt_reg <= 8'h00;
        end else begin
            unique case (state_reg)
                ST_IDLE: begin
                    state_reg <= ST_RUN;
                    stage_reg <= '0;
                end
                ST_RUN: begin
                    if (restart) begin
                        state_reg <= ST_IDLE;
                    end else if (dec_done) begin
                        stage_reg <= stage_next;
                        if (at_last) seq_cnt_reg <= seq_cnt_reg + 8'h01;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n || !run) begin
            cyc_reg <= '0;
        end else begin
            cyc_reg <= dec_done ? `CPS_CYC_W'(1) : cyc_reg + `CPS_CYC_W'(1);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            for (int s = 0; s < `CPS_STAGES; s++) res_mem[s] <= 16'h0000;
        end else if (stg_done) begin
            res_mem[stage_reg] <= dec_res;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // switch matrix and trim drive
    cps_trim_s cur_trim;
    assign cur_trim = trim_mem[stage_reg];
    wire [`CPS_ROUTE_W-1:0] cur_route = route_mem[stage_reg];
    logic [`CPS_PINS-1:0] pos_w;
    logic [`CPS_PINS-1:0] neg_w;
    logic [`CPS_PINS-1:0] grd_w;

    for (genvar p = 0; p < `CPS_PINS; p++) begin : g_pin
        wire cps_route_e rt = cps_route_e'(cur_route[2*p+1:2*p]);
        assign pos_w[p] = (rt == RT_POS);
        assign neg_w[p] = (rt == RT_NEG);
        assign grd_w[p] = (rt == RT_GUARD);
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_pin_pos   <= '0;
            o_pin_neg   <= '0;
            o_pin_guard <= '1;
            o_trim      <= cps_trim_s'(32'h0000_0000);
            o_stage     <= '0;
            o_cal_en    <= 1'b0;
        end else begin
            o_pin_pos   <= pos_w;
            o_pin_neg   <= neg_w;
            o_pin_guard <= grd_w;
            o_trim      <= cur_trim;
            o_stage     <= stage_reg;
            o_cal_en    <= calen_reg[stage_reg];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // results and differential buttons
    wire [16:0] hi_lim = {1'b0, `CPS_MID} + {9'h000, cur_trim.thr};
    wire [16:0] lo_lim = {1'b0, `CPS_MID} - {9'h000, cur_trim.thr};
    wire        over   = {1'b0, dec_res} > hi_lim;
    wire        under  = {1'b0, dec_res} < lo_lim;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            o_result       <= 16'h0000;
            o_result_valid <= 1'b0;
            o_seq_done     <= 1'b0;
            o_btn_a        <= 1'b0;
            o_btn_b        <= 1'b0;
        end else begin
            o_result_valid <= stg_done;
            o_seq_done     <= stg_done & at_last;
            if (stg_done) begin
                o_result <= dec_res;
                o_btn_a  <= cur_trim.diff & over & ~under;
                o_btn_b  <= cur_trim.diff & under & ~over;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_done_at_last;
        stg_done && at_last;
    endsequence

    sequence s_done_mid;
        stg_done && !at_last;
    endsequence

    chk_stage_wrap : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_done_at_last |=> stage_reg == '0 && run)
        else $error("no wrap to first stage");

    chk_stage_step : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        s_done_mid |=> stage_reg == $past(stage_reg) + 4'h1)
        else $error("stage did not step by one");

    chk_stage_hold : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        run && !dec_done |=> $stable(stage_reg) || state_reg == ST_IDLE)
        else $error("stage moved without result");

    chk_stage_max : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        stage_reg <= last_eff || state_reg == ST_IDLE || $changed(last_reg))
        else $error("stage beyond last");

    chk_stage_time : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        stg_done |-> cyc_reg == (half ? STAGE_CYC_LO : STAGE_CYC_HI))
        else $error("stage time wrong");

    chk_result_keep : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        stg_done |=> res_mem[$past(stage_reg)] == $past(dec_res) && o_result_valid)
        else $error("stage result not stored");

    chk_btn_excl : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        !(o_btn_a && o_btn_b))
        else $error("both buttons reported");

    chk_route_pos : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        ##1 o_pin_pos[0] == ($past(cur_route[1:0]) == RT_POS))
        else $error("pin routing not applied");

    chk_ahb_wait : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        accept |=> !o_hreadyout ##1 o_hreadyout)
        else $error("bus wait state wrong");
endmodule : cps_seq_top

// *** design/cps_tick.sv ***
// Purpose: modulator sample-rate tick and modulator bit synchroniser
// Assumes: modulator bit arrives asynchronously
// Notes:   divider restarts while i_clear is high
`timescale 1ns/1ps
`include "cps_consts.svh"
module cps_tick import cps_pkg::*; #(
    parameter int TICK_CYC = `CPS_TICK_CYC
) (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    input  wire logic i_clear,
    input  wire logic i_mod_bit,
    output logic      o_tick,
    output logic      o_bit
);
    logic [11:0] cnt_reg;
    logic        s1_reg;
    logic        s2_reg;

    assign o_tick = (cnt_reg == 12'(TICK_CYC - 1));
    assign o_bit  = s2_reg;

    always_ff @(posedge i_clk) begin
        if (!i_reset_n || i_clear) begin
            cnt_reg <= 12'h000;
        end else begin
            cnt_reg <= o_tick ? 12'h000 : cnt_reg + 12'h001;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
        end else begin
            s1_reg <= i_mod_bit;
            s2_reg <= s1_reg;
        end
    end

    chk_tick_spacing : assert property (@(posedge i_clk) disable iff (!i_reset_n)
        o_tick |=> (!o_tick)[*8])
        else $error("sample ticks too close");
endmodule : cps_tick

// *** inc/cps_consts.svh ***
// Purpose: shared constants of the capacitance conversion sequencer
// Assumes: 200 MHz system clock
// Notes:   offsets are AHB byte addresses
`ifndef CPS_CONSTS_SVH
`define CPS_CONSTS_SVH

`define CPS_PINS        14
`define CPS_STAGES      12
`define CPS_RES_W       16
`define CPS_TRIM_W      7
`define CPS_ROUTE_W     28
`define CPS_STG_W       4
`define CPS_CYC_W       20

`define CPS_CLK_HZ      200000000
`define CPS_CLK_NS      5
`define CPS_MOD_HZ      250000
`define CPS_TICK_CYC    (`CPS_CLK_HZ / `CPS_MOD_HZ)
`define CPS_T_STG_HI_NS 3072000
`define CPS_T_STG_LO_NS 1536000

`define CPS_DEC_LSB     8
`define CPS_DEC_128     2'h1
`define CPS_RATIO_HI    256
`define CPS_RATIO_LO    128
`define CPS_OSR_MUL     3
`define CPS_N_HI        (`CPS_OSR_MUL * `CPS_RATIO_HI)
`define CPS_N_LO        (`CPS_OSR_MUL * `CPS_RATIO_LO)
`define CPS_SCALE_HI    8'h55
`define CPS_SCALE_LO    8'hAA
`define CPS_MID         16'h8000

`define CPS_A_CTRL      12'h000
`define CPS_A_LAST      12'h004
`define CPS_A_CALEN     12'h008
`define CPS_A_STAT      12'h00C
`define CPS_A_STG_BASE  12'h040
`define CPS_A_STG_END   12'h0FC
`define CPS_STG_IDX_OFS 4'h4
`define CPS_W_ROUTE     2'h0
`define CPS_W_TRIM      2'h1
`define CPS_W_RES       2'h2

`define CPS_LAST_RST    4'hB
`define CPS_LAST_MAX    4'hB
`define CPS_ROUTE_RST   28'hFFF_FFFF
`define CPS_TRIM_MASK   32'hFF01_FFFF

`endif

// *** inc/cps_pkg.sv ***
// Purpose: types of the capacitance conversion sequencer
// Assumes: cps_consts.svh holds all numbers
// Notes:   trim word layout is the packed struct below
package cps_pkg;
`include "cps_consts.svh"

    typedef enum logic [1:0] {
        RT_OPEN  = 2'h0,
        RT_POS   = 2'h1,
        RT_NEG   = 2'h2,
        RT_GUARD = 2'h3
    } cps_route_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_RUN  = 2'h1
    } cps_state_e;

    typedef struct packed {
        logic [7:0]             thr;
        logic [6:0]             pad;
        logic                   diff;
        logic                   neg_on_pos;
        logic [`CPS_TRIM_W-1:0] neg_trim;
        logic                   pos_on_neg;
        logic [`CPS_TRIM_W-1:0] pos_trim;
    } cps_trim_s;

endpackage : cps_pkg

// *** sim/cps_mod_model.sv ***
// Purpose: modulator bit source in place of the sensor front end
// Assumes: any ones density is legal
// Notes:   pattern repeats every 8 cycles, high up to three cycles in a row
`timescale 1ns/1ps
module cps_mod_model (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    output logic      o_mod_bit
);
    logic [2:0] ph_reg;
    always_ff @(posedge i_clk) begin
        ph_reg <= i_reset_n ? ph_reg + 3'h1 : 3'h0;
    end
    assign o_mod_bit = ph_reg[0] | (ph_reg == 3'h2);
endmodule : cps_mod_model

// *** sim/test_capacitance_conversion_sequencer.sv ***
// Purpose: register and routing tests of the sequencer over AHB-Lite
// Assumes: one wait state per access, hready looped back
// Notes:   a stage lasts far beyond the run, so stage results stay unseen
`timescale 1ns/1ps
`include "cps_consts.svh"
module test_capacitance_conversion_sequencer import cps_pkg::*;;
    logic        i_clk, i_reset_n, hsel, hwrite, hready, hresp, mod_bit;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [13:0] pin_pos, pin_neg, pin_guard, e_pos, e_neg, e_guard;
    logic [3:0]  stage;
    logic [27:0] r;
    cps_trim_s   trim;
    logic [15:0] result;
    logic        cal_en, res_valid, seq_done, btn_a, btn_b;
    int          err_count, total_checks, cyc, n_valid;

    cps_seq_top cps_seq_top_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
        .i_mod_bit(mod_bit), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(hresp),
        .o_pin_pos(pin_pos), .o_pin_neg(pin_neg), .o_pin_guard(pin_guard), .o_trim(trim), .o_stage(stage),
        .o_cal_en(cal_en), .o_result(result), .o_result_valid(res_valid), .o_seq_done(seq_done),
        .o_btn_a(btn_a), .o_btn_b(btn_b));
    cps_mod_model cps_mod_model_i (.i_clk(i_clk), .i_reset_n(i_reset_n), .o_mod_bit(mod_bit));

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end

    always @(posedge i_clk) begin
        cyc++;
        // a stage outlasts the whole run, so no result may appear yet
        if (i_reset_n === 1'b1 && {result, res_valid, seq_done, btn_a, btn_b} !== 20'h0_0000) n_valid++;
        if (cyc == 3000) begin
            err_count++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge i_clk);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= wr;
        @(posedge i_clk);
        while (hready !== 1'b1) @(posedge i_clk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge i_clk);
        while (hready !== 1'b1) @(posedge i_clk);
        q = hrdata;
    endtask : xfer

    task automatic rd(input logic [31:0] a, input logic [31:0] exp);
        xfer(1'b0, a, 32'h0000_0000);
        check(q, exp);
    endtask : rd

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        i_reset_n = 1'b0;
        hsel = 1'b0;
        htrans = 2'h0;
        hwrite = 1'b0;
        haddr = 32'h0000_0000;
        hwdata = 32'h0000_0000;
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'b1;
        check({18'h0, pin_guard}, 32'h0000_3FFF);
        check({28'h0, stage}, 32'h0000_0000);
        check({31'h0, hresp}, 32'h0000_0000);
        rd(32'h0000_0000, 32'h0000_0000);
        rd(32'h0000_0004, 32'h0000_000B);
        rd(32'h0000_0008, 32'h0000_0000);
        rd(32'h0000_0040, 32'h0FFF_FFFF);
        $display("test reset values done");
        for (int s = 0; s < 12; s++) xfer(1'b1, 32'h40 + 16 * s, 32'h0123_4567 + 17 * s);
        for (int s = 0; s < 12; s++) rd(32'h40 + 16 * s, 32'h0123_4567 + 17 * s);
        $display("test per stage routing done");
        xfer(1'b1, 32'h0000_0074, 32'hFFFF_FFFF);
        rd(32'h0000_0074, 32'hFF01_FFFF);
        xfer(1'b1, 32'h0000_0074, 32'h0000_8080);
        rd(32'h0000_0074, 32'h0000_8080);
        $display("test trim fields done");
        xfer(1'b1, 32'h0000_0004, 32'h0000_0005);
        rd(32'h0000_0004, 32'h0000_0005);
        xfer(1'b1, 32'h0000_0000, 32'h0000_0100);
        rd(32'h0000_0000, 32'h0000_0100);
        rd(32'h0000_000C, 32'h0000_0010);
        r = 28'h123_4567;
        for (int p = 0; p < 14; p++) begin
            e_pos[p] = r[2*p +: 2] == 2'h1;
            e_neg[p] = r[2*p +: 2] == 2'h2;
            e_guard[p] = r[2*p +: 2] == 2'h3;
        end
        check({18'h0, pin_pos}, {18'h0, e_pos});
        check({18'h0, pin_neg}, {18'h0, e_neg});
        check({18'h0, pin_guard}, {18'h0, e_guard});
        $display("test control and routing outputs done");
        xfer(1'b1, 32'h0000_0008, 32'h0000_003F);
        xfer(1'b1, 32'h0000_0044, 32'h1201_0305);
        xfer(1'b1, 32'h0000_0054, 32'h2001_0000);
        check({31'h0, cal_en}, 32'h0000_0001);
        check(trim, 32'h1201_0305);
        rd(32'h0000_0008, 32'h0000_003F);
        rd(32'h0000_0054, 32'h2001_0000);
        $display("test stage trim and calibration outputs done");
        xfer(1'b1, 32'h0000_0800, 32'hFFFF_FFFF);
        rd(32'h0000_0800, 32'h0000_0000);
        xfer(1'b1, 32'h0000_0048, 32'h0000_1234);
        rd(32'h0000_0048, 32'h0000_0000);
        $display("test unmapped and read-only done");
        check(n_valid, 0);
        results();
    end
endmodule : test_capacitance_conversion_sequencer
